// File: hw/lstu_pkg.sv
// Constants, encodings and helpers for the load/store transfer unit
package lstu_pkg;

  localparam int unsigned INSTR_W = 16;
  localparam int unsigned REG_W   = 24;
  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_GPR = 8;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned IMM_W   = 7;

  // Instruction word fields
  localparam int unsigned OP_HI   = 15;
  localparam int unsigned OP_LO   = 10;
  localparam int unsigned RD_HI   = 9;
  localparam int unsigned RD_LO   = 7;
  localparam int unsigned RB_HI   = 6;
  localparam int unsigned RB_LO   = 4;
  localparam int unsigned MODE_HI = 3;
  localparam int unsigned MODE_LO = 2;
  localparam int unsigned IMM_HI  = 6;
  localparam int unsigned IMM_LO  = 0;
  localparam int unsigned KIND_HI = 5;
  localparam int unsigned KIND_LO = 2;
  localparam int unsigned EXT_HI  = 1;
  localparam int unsigned EXT_LO  = 0;

  // Operand width and extension, low two opcode bits
  localparam logic [1:0] EXT_SBYTE = 2'h0;
  localparam logic [1:0] EXT_UBYTE = 2'h1;
  localparam logic [1:0] EXT_HALF  = 2'h2;
  localparam logic [1:0] EXT_WORD  = 2'h3;

  // Operation kind, high four opcode bits
  localparam logic [3:0] KIND_MOVE    = 4'h0;
  localparam logic [3:0] KIND_IMM     = 4'h1;
  localparam logic [3:0] KIND_LD_BASE = 4'h2;
  localparam logic [3:0] KIND_LD_SPOF = 4'h3;
  localparam logic [3:0] KIND_LD_ABS  = 4'h4;
  localparam logic [3:0] KIND_ST_BASE = 4'h5;
  localparam logic [3:0] KIND_ST_SPOF = 4'h6;
  localparam logic [3:0] KIND_ST_ABS  = 4'h7;
  localparam logic [3:0] KIND_FROM_SP = 4'h8;
  localparam logic [3:0] KIND_FROM_PC = 4'h9;
  localparam logic [3:0] KIND_LD_SP   = 4'hA;

  // Base register update modes
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h3;

  // Memory access size codes on the data bus
  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h00_0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 24'h00_0002;
  localparam logic [ADDR_W-1:0] STEP_WORD = 24'h00_0004;

  localparam logic [REG_W-1:0] GPR_RESET = 24'h00_0000;
  localparam logic [REG_W-1:0] SP_RESET  = 24'h00_0000;
  localparam logic [3:0]       OBS_SP_SEL = 4'h8;

  // Widen a fetched or moved value into a register by operand width
  function automatic logic [REG_W-1:0] extend_value(input logic [1:0]        ext,
                                                    input logic [DATA_W-1:0] d);
    unique case (ext)
      EXT_SBYTE: extend_value = {{16{d[7]}}, d[7:0]};
      EXT_UBYTE: extend_value = {16'h0000, d[7:0]};
      EXT_HALF:  extend_value = {8'h00, d[15:0]};
      EXT_WORD:  extend_value = d[REG_W-1:0];
    endcase
  endfunction : extend_value

  function automatic logic [ADDR_W-1:0] step_bytes(input logic [1:0] ext);
    unique case (ext)
      EXT_SBYTE: step_bytes = STEP_BYTE;
      EXT_UBYTE: step_bytes = STEP_BYTE;
      EXT_HALF:  step_bytes = STEP_HALF;
      EXT_WORD:  step_bytes = STEP_WORD;
    endcase
  endfunction : step_bytes

  function automatic logic [1:0] size_code(input logic [1:0] ext);
    unique case (ext)
      EXT_SBYTE: size_code = SIZE_8;
      EXT_UBYTE: size_code = SIZE_8;
      EXT_HALF:  size_code = SIZE_16;
      EXT_WORD:  size_code = SIZE_32;
    endcase
  endfunction : size_code

endpackage : lstu_pkg

// File: hw/lstu_rf_if.sv
// Register file ports shared by the transfer unit and its register file
`timescale 1ns/1ps
interface lstu_rf_if;
  logic [2:0]  rs_idx;
  logic [2:0]  rb_idx;
  logic [2:0]  obs_idx;
  logic [23:0] rs_data;
  logic [23:0] rb_data;
  logic [23:0] obs_data;
  logic [23:0] sp_data;
  logic        wa_en;
  logic [2:0]  wa_idx;
  logic [23:0] wa_data;
  logic        ws_en;
  logic [23:0] ws_data;
  logic        wb_en;
  logic [2:0]  wb_idx;
  logic [23:0] wb_data;

  modport core (output rs_idx, rb_idx, obs_idx, wa_en, wa_idx, wa_data,
                output ws_en, ws_data, wb_en, wb_idx, wb_data,
                input  rs_data, rb_data, obs_data, sp_data);
  modport file (input  rs_idx, rb_idx, obs_idx, wa_en, wa_idx, wa_data,
                input  ws_en, ws_data, wb_en, wb_idx, wb_data,
                output rs_data, rb_data, obs_data, sp_data);
endinterface : lstu_rf_if

// File: hw/lstu_regfile.sv
// Eight general registers and the stack pointer, three read ports
`timescale 1ns/1ps
module lstu_regfile (
  input wire logic ref_clk,
  input wire logic rst,
  lstu_rf_if.file  rf
);

  logic [lstu_pkg::REG_W-1:0] gpr_q [lstu_pkg::NUM_GPR];
  logic [lstu_pkg::REG_W-1:0] sp_q;

  // Issue-time write is from the younger instruction, so it overrides
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lstu_pkg::NUM_GPR; i++) begin
        gpr_q[i] <= lstu_pkg::GPR_RESET;
      end
    end else begin
      if (rf.wb_en) begin
        gpr_q[rf.wb_idx] <= rf.wb_data;
      end
      if (rf.wa_en) begin
        gpr_q[rf.wa_idx] <= rf.wa_data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_q <= lstu_pkg::SP_RESET;
    end else if (rf.ws_en) begin
      sp_q <= rf.ws_data;
    end
  end

  assign rf.rs_data  = gpr_q[rf.rs_idx];
  assign rf.rb_data  = gpr_q[rf.rb_idx];
  assign rf.obs_data = gpr_q[rf.obs_idx];
  assign rf.sp_data  = sp_q;

endmodule : lstu_regfile

// File: hw/lstu_unit.sv
// Load/store/move transfer unit: decode, address generation, memory issue, writeback
// Summary of operation
// [RULE1] Instruction words are fixed at sixteen bits; no longer encodings exist.
// [RULE2] A new transfer instruction is accepted on every clock cycle.
// [RULE3] Signed byte loads and moves sign-extend the byte into the destination.
// [RULE4] Unsigned byte loads and moves zero-extend the byte into the destination.
// [RULE5] Byte stores write only the source low byte, by base, stack offset or absolute.
// [RULE6] Base-register accesses support plain, post-increment, post-decrement, pre-decrement.
// [RULE7] Halfword loads bring sixteen bits from memory, stack or absolute address.
// [RULE8] Halfword register move copies sixteen bits of the source.
// [RULE9] Halfword stores write sixteen bits by stack offset, base or absolute address.
// [RULE10] Halfword immediate load sign-extends a signed seven-bit field.
// [RULE11] Address-width immediate load zero-extends an unsigned seven-bit field.
// [RULE12] Address-width register move copies all twenty-four source bits.
// [RULE13] Address-width loads read a thirty-two-bit word by base, stack offset, absolute.
// [RULE14] Address-width stores write a thirty-two-bit word, upper bits zero.
// [RULE15] A move copies the stack pointer into a general register.
// [RULE16] A move copies the program counter into a general register.
// [RULE17] Word load through the stack pointer supports post-inc, post-dec, pre-dec.
// [RULE18] Eight general registers, each twenty-four bits wide.
// [RULE19] Effective addresses are twenty-four bits wide.
// [RULE20] Post forms adjust by access size after, pre-decrement before the transfer.
// [RULE21] The stack offset is unsigned and added to the stack pointer.
`timescale 1ns/1ps
module lstu_unit (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [23:0] instr_pc,
  output logic             mem_req_q,
  output logic             mem_write_q,
  output logic [1:0]       mem_size_q,
  output logic [23:0]      mem_addr_q,
  output logic [31:0]      mem_wdata_q,
  input  wire logic [31:0] mem_rdata,
  output logic             retire_q,
  output logic             illegal_q,
  input  wire logic [3:0]  obs_sel,
  output logic [23:0]      obs_data_q
);

  lstu_rf_if rf ();

  lstu_regfile u_regfile (
    .ref_clk (ref_clk),
    .rst     (rst),
    .rf      (rf.file)
  );

  // Pending load writeback, one cycle behind the memory request
  logic                                 wb_en_q;
  logic [lstu_pkg::IDX_W-1:0]           wb_idx_q;
  logic [1:0]                           ld_ext_q;
  logic [lstu_pkg::REG_W-1:0]           wb_val;

  // Decoded fields
  logic [lstu_pkg::INSTR_W-1:0]         word;
  logic [3:0]                           kind;
  logic [1:0]                           ext;
  logic [1:0]                           mode;
  logic [lstu_pkg::IDX_W-1:0]           rd;
  logic [lstu_pkg::IDX_W-1:0]           rb;
  logic [lstu_pkg::IMM_W-1:0]           imm;

  // Operands after forwarding
  logic [lstu_pkg::REG_W-1:0]           rs_val;
  logic [lstu_pkg::REG_W-1:0]           rb_val;
  logic [lstu_pkg::REG_W-1:0]           sp_val;
  logic [lstu_pkg::ADDR_W-1:0]          step;
  logic [lstu_pkg::ADDR_W-1:0]          imm_zx;
  logic [lstu_pkg::REG_W-1:0]           imm_sx;

  // Issue-cycle results
  logic                                 legal;
  logic                                 issue_mem;
  logic                                 issue_write;
  logic                                 issue_load;
  logic [lstu_pkg::ADDR_W-1:0]          ea;
  logic [lstu_pkg::DATA_W-1:0]          st_data;
  logic                                 wa_en;
  logic [lstu_pkg::IDX_W-1:0]           wa_idx;
  logic [lstu_pkg::REG_W-1:0]           wa_data;
  logic                                 ws_en;
  logic [lstu_pkg::REG_W-1:0]           ws_data;

  // Bypass a load that is writing back this cycle
  function automatic logic [lstu_pkg::REG_W-1:0] fwd(
    input logic [lstu_pkg::IDX_W-1:0] idx,
    input logic [lstu_pkg::REG_W-1:0] file_val
  );
    if (wb_en_q && (wb_idx_q == idx)) begin
      fwd = wb_val;
    end else begin
      fwd = file_val;
    end
  endfunction : fwd

  // Address and base update for one of the four base forms
  function automatic logic [lstu_pkg::ADDR_W-1:0] mode_addr(
    input logic [1:0]                  m,
    input logic [lstu_pkg::ADDR_W-1:0] base,
    input logic [lstu_pkg::ADDR_W-1:0] sz
  );
    if (m == lstu_pkg::MODE_PRE_DEC) begin
      mode_addr = base - sz; // RULE20
    end else begin
      mode_addr = base;
    end
  endfunction : mode_addr

  function automatic logic [lstu_pkg::ADDR_W-1:0] mode_update(
    input logic [1:0]                  m,
    input logic [lstu_pkg::ADDR_W-1:0] base,
    input logic [lstu_pkg::ADDR_W-1:0] sz
  );
    if (m == lstu_pkg::MODE_POST_INC) begin
      mode_update = base + sz; // RULE20
    end else begin
      mode_update = base - sz; // RULE20
    end
  endfunction : mode_update

  assign word   = instr_word; // RULE1
  // Kind and extension fields sit inside the opcode, counted from its low bit
  assign kind   = word[lstu_pkg::OP_LO+lstu_pkg::KIND_HI:lstu_pkg::OP_LO+lstu_pkg::KIND_LO];
  assign ext    = word[lstu_pkg::OP_LO+lstu_pkg::EXT_HI:lstu_pkg::OP_LO+lstu_pkg::EXT_LO];
  assign mode   = word[lstu_pkg::MODE_HI:lstu_pkg::MODE_LO];
  assign rd     = word[lstu_pkg::RD_HI:lstu_pkg::RD_LO];
  assign rb     = word[lstu_pkg::RB_HI:lstu_pkg::RB_LO];
  assign imm    = word[lstu_pkg::IMM_HI:lstu_pkg::IMM_LO];

  assign rf.rs_idx  = rd;
  assign rf.rb_idx  = rb;
  assign rf.obs_idx = obs_sel[2:0];

  assign wb_val = lstu_pkg::extend_value(ld_ext_q, mem_rdata); // RULE3 RULE4 RULE7 RULE13
  assign rs_val = fwd(rd, rf.rs_data);
  assign rb_val = fwd(rb, rf.rb_data);
  assign sp_val = rf.sp_data;
  assign step   = lstu_pkg::step_bytes(ext);
  assign imm_zx = {17'h0_0000, imm};
  assign imm_sx = {{17{imm[6]}}, imm}; // RULE10

  // Decode and execute in the issue cycle
  always_comb begin
    legal       = 1'b0;
    issue_mem   = 1'b0;
    issue_write = 1'b0;
    issue_load  = 1'b0;
    ea          = {lstu_pkg::ADDR_W{1'b0}};
    st_data     = {lstu_pkg::DATA_W{1'b0}};
    wa_en       = 1'b0;
    wa_idx      = rd;
    wa_data     = {lstu_pkg::REG_W{1'b0}};
    ws_en       = 1'b0;
    ws_data     = sp_val;
    unique case (kind)
      lstu_pkg::KIND_MOVE: begin
        legal   = 1'b1;
        wa_en   = 1'b1;
        wa_data = lstu_pkg::extend_value(ext, {8'h00, rb_val}); // RULE3 RULE4 RULE8 RULE12
      end
      lstu_pkg::KIND_IMM: begin
        if (ext == lstu_pkg::EXT_HALF) begin
          legal   = 1'b1;
          wa_en   = 1'b1;
          wa_data = imm_sx; // RULE10
        end else if (ext == lstu_pkg::EXT_WORD) begin
          legal   = 1'b1;
          wa_en   = 1'b1;
          wa_data = imm_zx; // RULE11
        end
      end
      lstu_pkg::KIND_LD_BASE, lstu_pkg::KIND_ST_BASE: begin
        legal       = (kind == lstu_pkg::KIND_LD_BASE) || (ext != lstu_pkg::EXT_UBYTE);
        issue_mem   = 1'b1;
        issue_write = (kind == lstu_pkg::KIND_ST_BASE);
        issue_load  = (kind == lstu_pkg::KIND_LD_BASE);
        ea          = mode_addr(mode, rb_val, step); // RULE6 RULE19
        wa_en       = (mode != lstu_pkg::MODE_PLAIN); // RULE6
        wa_idx      = rb;
        wa_data     = mode_update(mode, rb_val, step); // RULE20
      end
      lstu_pkg::KIND_LD_SPOF, lstu_pkg::KIND_ST_SPOF: begin
        legal       = (kind == lstu_pkg::KIND_LD_SPOF) || (ext != lstu_pkg::EXT_UBYTE);
        issue_mem   = 1'b1;
        issue_write = (kind == lstu_pkg::KIND_ST_SPOF);
        issue_load  = (kind == lstu_pkg::KIND_LD_SPOF);
        ea          = sp_val + imm_zx; // RULE21
      end
      lstu_pkg::KIND_LD_ABS, lstu_pkg::KIND_ST_ABS: begin
        legal       = (kind == lstu_pkg::KIND_LD_ABS) || (ext != lstu_pkg::EXT_UBYTE);
        issue_mem   = 1'b1;
        issue_write = (kind == lstu_pkg::KIND_ST_ABS);
        issue_load  = (kind == lstu_pkg::KIND_LD_ABS);
        ea          = imm_zx;
      end
      lstu_pkg::KIND_FROM_SP: begin
        legal   = (ext == lstu_pkg::EXT_WORD);
        wa_en   = 1'b1;
        wa_data = sp_val; // RULE15
      end
      lstu_pkg::KIND_FROM_PC: begin
        legal   = (ext == lstu_pkg::EXT_WORD);
        wa_en   = 1'b1;
        wa_data = instr_pc; // RULE16
      end
      lstu_pkg::KIND_LD_SP: begin
        legal      = (ext == lstu_pkg::EXT_WORD);
        issue_mem  = 1'b1;
        issue_load = 1'b1;
        ea         = mode_addr(mode, sp_val, step); // RULE17
        ws_en      = (mode != lstu_pkg::MODE_PLAIN); // RULE17
        ws_data    = mode_update(mode, sp_val, step); // RULE17
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    // Store data: only the lanes of the access size, upper bits zero
    unique case (ext)
      lstu_pkg::EXT_SBYTE: st_data = {24'h00_0000, rs_val[7:0]}; // RULE5
      lstu_pkg::EXT_UBYTE: st_data = {24'h00_0000, rs_val[7:0]};
      lstu_pkg::EXT_HALF:  st_data = {16'h0000, rs_val[15:0]}; // RULE9
      lstu_pkg::EXT_WORD:  st_data = {8'h00, rs_val}; // RULE14
    endcase
    if (!instr_valid || !legal) begin
      issue_mem   = 1'b0;
      issue_write = 1'b0;
      issue_load  = 1'b0;
      wa_en       = 1'b0;
      ws_en       = 1'b0;
    end
  end

  // Issue-time register and stack pointer writes
  assign rf.wa_en   = wa_en; // RULE2
  assign rf.wa_idx  = wa_idx;
  assign rf.wa_data = wa_data;
  assign rf.ws_en   = ws_en;
  assign rf.ws_data = ws_data;

  // Load data lands one cycle after its request
  assign rf.wb_en   = wb_en_q; // RULE18
  assign rf.wb_idx  = wb_idx_q;
  assign rf.wb_data = wb_val;

  // Data bus request, registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_req_q   <= 1'b0;
      mem_write_q <= 1'b0;
      mem_size_q  <= lstu_pkg::SIZE_8;
      mem_addr_q  <= {lstu_pkg::ADDR_W{1'b0}};
      mem_wdata_q <= {lstu_pkg::DATA_W{1'b0}};
    end else begin
      mem_req_q   <= issue_mem; // RULE2
      mem_write_q <= issue_write;
      if (issue_mem) begin
        mem_size_q  <= lstu_pkg::size_code(ext);
        mem_addr_q  <= ea; // RULE19
        mem_wdata_q <= issue_write ? st_data : {lstu_pkg::DATA_W{1'b0}};
      end
    end
  end

  // Pending writeback bookkeeping
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_en_q  <= 1'b0;
      wb_idx_q <= {lstu_pkg::IDX_W{1'b0}};
      ld_ext_q <= lstu_pkg::EXT_SBYTE;
    end else begin
      wb_en_q <= issue_load;
      if (issue_load) begin
        wb_idx_q <= rd;
        ld_ext_q <= ext; // RULE3 RULE4
      end
    end
  end

  // Completion and decode-fault pulses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      retire_q  <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      retire_q  <= instr_valid && legal; // RULE2
      illegal_q <= instr_valid && !legal;
    end
  end

  // Register observation port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      obs_data_q <= {lstu_pkg::REG_W{1'b0}};
    end else if (obs_sel == lstu_pkg::OBS_SP_SEL) begin
      obs_data_q <= sp_val;
    end else if (obs_sel[3]) begin
      obs_data_q <= {lstu_pkg::REG_W{1'b0}};
    end else begin
      obs_data_q <= rf.obs_data;
    end
  end

endmodule : lstu_unit

// File: dv/lstu_mem_model.sv
// Zero-wait data memory model on the far side of the transfer unit bus
`timescale 1ns/1ps
module lstu_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mem_req_q,
  input  wire logic [23:0] mem_addr_q,
  output logic      [31:0] mem_rdata
);
  logic [31:0] noise_q;

  // Fixed content per byte address; the bus allows no wait states
  function automatic logic [31:0] word_at(input logic [23:0] a);
    return {~a[7:0], a[15:8] ^ a[23:16], a[7:0] + 8'h37, a[7:0] ^ a[15:8] ^ 8'h96};
  endfunction : word_at

  // Undriven data lines outside a request change every cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) noise_q <= 32'h5a5a_a5a5;
    else noise_q <= ~noise_q + 32'h0001_3579;
  end

  assign mem_rdata = mem_req_q ? word_at(mem_addr_q) : noise_q;
endmodule : lstu_mem_model

// File: dv/lstu_unit_assertions.sv
// Port-level checks of the transfer unit
`timescale 1ns/1ps
module lstu_unit_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [23:0] instr_pc,
  input wire logic        mem_req_q,
  input wire logic        mem_write_q,
  input wire logic [1:0]  mem_size_q,
  input wire logic [23:0] mem_addr_q,
  input wire logic [31:0] mem_wdata_q,
  input wire logic [31:0] mem_rdata,
  input wire logic        retire_q,
  input wire logic        illegal_q,
  input wire logic [3:0]  obs_sel,
  input wire logic [23:0] obs_data_q
);
  logic [3:0] k;
  logic [1:0] x;
  logic       is_mem;
  logic       is_legal;
  assign k = instr_word[15:12];
  assign x = instr_word[11:10];
  assign is_mem = k inside {4'h2, 4'h3, 4'h4} || (k inside {4'h5, 4'h6, 4'h7} && x != 2'h1)
                  || (k == 4'hA && x == 2'h3);
  assign is_legal = is_mem || k == 4'h0 || (k == 4'h1 && x[1])
                    || (k inside {4'h8, 4'h9} && x == 2'h3);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  one_answer_a: assert property (instr_valid |=>
    retire_q == $past(is_legal) && illegal_q == !$past(is_legal)) else $error("bad answer");
  no_stray_answer_a: assert property (!instr_valid |=> !retire_q && !illegal_q)
    else $error("answer without instruction");
  mem_issue_a: assert property (instr_valid && is_mem |=>
    mem_req_q && mem_write_q == $past(k inside {4'h5, 4'h6, 4'h7})) else $error("no access");
  access_size_a: assert property (instr_valid && is_mem |=> mem_size_q ==
    ($past(x) == 2'h3 ? 2'h2 : $past(x) == 2'h2 ? 2'h1 : 2'h0)) else $error("bad size");
  no_stray_req_a: assert property (mem_req_q |-> $past(instr_valid && is_mem))
    else $error("request without access");
  abs_address_a: assert property (instr_valid && is_mem && k inside {4'h4, 4'h7} |=>
    mem_addr_q == {17'h0_0000, $past(instr_word[6:0])}) else $error("bad address");
  word_store_a: assert property (mem_req_q && mem_write_q && mem_size_q == 2'h2 |->
    mem_wdata_q[31:24] == 8'h00) else $error("word store upper bits");
  byte_store_a: assert property (mem_req_q && mem_write_q && mem_size_q == 2'h0 |->
    mem_wdata_q[31:8] == 24'h00_0000) else $error("byte store upper bits");
  half_store_a: assert property (mem_req_q && mem_write_q && mem_size_q == 2'h1 |->
    mem_wdata_q[31:16] == 16'h0000) else $error("half store upper bits");
  load_wdata_a: assert property (mem_req_q && !mem_write_q |-> mem_wdata_q == 32'h0000_0000)
    else $error("load with write data");
  full_rate_a: assert property ((instr_valid && is_legal)[*3] |=>
    retire_q && $past(retire_q) && $past(retire_q, 2)) else $error("throughput lost");
  obs_unused_a: assert property (obs_sel > 4'h8 |=> obs_data_q == 24'h00_0000)
    else $error("unused view not zero");

  cover property (instr_valid && is_mem ##1 instr_valid && is_mem);
  cover property (illegal_q);
  cover property (mem_req_q && mem_write_q && mem_size_q == 2'h2);
endmodule : lstu_unit_assertions

bind lstu_unit lstu_unit_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
  .mem_req_q(mem_req_q), .mem_write_q(mem_write_q), .mem_size_q(mem_size_q),
  .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata),
  .retire_q(retire_q), .illegal_q(illegal_q), .obs_sel(obs_sel), .obs_data_q(obs_data_q));

// File: dv/load_store_transfer_unit_tb.sv
// Self-checking bench for the transfer unit with a reference model
`timescale 1ns/1ps
module load_store_transfer_unit_tb;
  typedef struct packed {
    logic        ret;
    logic        ill;
    logic        req;
    logic        wr;
    logic [1:0]  sz;
    logic [23:0] a;
    logic [31:0] wd;
  } lstu_exp_t;

  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word  = 16'h0000;
  logic [23:0] instr_pc    = 24'h00_0000;
  logic [3:0]  obs_sel     = 4'h0;
  logic        mem_req_q;
  logic        mem_write_q;
  logic [1:0]  mem_size_q;
  logic [23:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  logic [31:0] mem_rdata;
  logic        retire_q;
  logic        illegal_q;
  logic [23:0] obs_data_q;
  logic [23:0] gpr [8];
  logic [23:0] sp_m;
  logic [31:0] lfsr        = 32'h0000_f73c;
  lstu_exp_t   exp_q [$];
  int          fails       = 0;
  int          n_compared  = 0;
  logic [15:0] dir [14] = '{16'h2094, 16'h5D2C, 16'h29C8, 16'h0EB0, 16'hAF00, 16'hAF04,
                            16'hAF08, 16'hAF0C, 16'h18C0, 16'h1D7F, 16'h61FF, 16'h367F,
                            16'h8F80, 16'h7E80};

  always #25 ref_clk = ~ref_clk;

  lstu_unit dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .mem_req_q(mem_req_q),
    .mem_write_q(mem_write_q), .mem_size_q(mem_size_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .retire_q(retire_q),
    .illegal_q(illegal_q), .obs_sel(obs_sel), .obs_data_q(obs_data_q));

  lstu_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [23:0] ext_val(input logic [1:0] x, input logic [31:0] v);
    case (x)
      2'h0: return {{16{v[7]}}, v[7:0]};
      2'h1: return {16'h0000, v[7:0]};
      2'h2: return {8'h00, v[15:0]};
      default: return v[23:0];
    endcase
  endfunction : ext_val

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Drives one word, then updates the model in program order
  task automatic exec(input logic [15:0] w, input logic [23:0] pc);
    lstu_exp_t   e;
    logic [3:0]  k;
    logic [1:0]  x;
    logic [2:0]  d;
    logic [2:0]  b;
    logic [23:0] st;
    logic [23:0] bv;
    logic [23:0] v;
    instr_word <= w;
    instr_pc <= pc;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    {k, x, d, b} = w[15:4];
    st = x == 2'h3 ? 24'h00_0004 : x == 2'h2 ? 24'h00_0002 : 24'h00_0001;
    e = '0;
    e.sz = x == 2'h3 ? 2'h2 : x == 2'h2 ? 2'h1 : 2'h0;
    bv = k == 4'hA ? sp_m : gpr[b];
    v = gpr[d];
    e.ill = !(k == 4'h0 || (k == 4'h1 && x[1]) || k inside {4'h2, 4'h3, 4'h4}
      || (k inside {4'h5, 4'h6, 4'h7} && x != 2'h1) || (k inside {4'h8, 4'h9, 4'hA} && x == 2'h3));
    e.ret = !e.ill;
    e.req = !e.ill && k inside {[4'h2:4'h7], 4'hA};
    e.wr = k inside {4'h5, 4'h6, 4'h7};
    if (k inside {4'h3, 4'h6}) e.a = sp_m + {17'h0_0000, w[6:0]};
    else if (k inside {4'h4, 4'h7}) e.a = {17'h0_0000, w[6:0]};
    else e.a = w[3:2] == 2'h3 ? bv - st : bv;
    if (e.wr) e.wd = x == 2'h3 ? {8'h00, v} : x == 2'h2 ? {16'h0000, v[15:0]} : {24'h00_0000, v[7:0]};
    if (e.req && k inside {4'h2, 4'h5, 4'hA} && w[3:2] != 2'h0) begin
      bv = w[3:2] == 2'h1 ? bv + st : bv - st;
      if (k == 4'hA) sp_m = bv;
      else gpr[b] = bv;
    end
    if (e.req && !e.wr) gpr[d] = ext_val(x, u_mem.word_at(e.a));
    if (!e.ill && k == 4'h0) gpr[d] = ext_val(x, {8'h00, gpr[b]});
    if (!e.ill && k == 4'h1) gpr[d] = x[0] ? {17'h0_0000, w[6:0]} : {{17{w[6]}}, w[6:0]};
    if (!e.ill && k == 4'h8) gpr[d] = sp_m;
    if (!e.ill && k == 4'h9) gpr[d] = pc;
    exp_q.push_back(e);
  endtask : exec

  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic chk_regs(input string name);
    idle(1);
    for (int i = 0; i < 10; i++) begin
      obs_sel <= 4'(i);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("register", i < 8 ? gpr[i] : i == 8 ? sp_m : 24'h00_0000, obs_data_q);
      @(posedge ref_clk);
    end
    $display("test %s done", name);
  endtask : chk_regs

  task automatic do_reset();
    instr_valid <= 1'b0;
    rst <= 1'b1;
    exp_q.delete();
    sp_m = 24'h00_0000;
    foreach (gpr[i]) gpr[i] = 24'h00_0000;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset

  // Every cycle out of reset: the answer of the word taken at the last edge
  always @(negedge ref_clk) begin : mon
    lstu_exp_t e;
    e = '0;
    if (!rst) begin
      if (exp_q.size() > 0) e = exp_q.pop_front();
      chk("retire", e.ret, retire_q);
      chk("illegal", e.ill, illegal_q);
      chk("request", e.req, mem_req_q);
      if (e.req) begin
        chk("write", e.wr, mem_write_q);
        chk("size", e.sz, mem_size_q);
        chk("address", e.a, mem_addr_q);
        chk("wdata", e.wd, mem_wdata_q);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    finish_test();
  end

  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      exec({4'h9, 2'h3, 3'(i), 7'h00}, lfsr[23:0]);
    end
    chk_regs("preload");
    for (int k = 0; k < 16; k++) begin
      for (int x = 0; x < 4; x++) begin
        lfsr = lfsr_next(lfsr);
        exec({4'(k), 2'(x), lfsr[9:0]}, lfsr[31:8]);
      end
    end
    chk_regs("all codes");
    foreach (dir[i]) exec(dir[i], 24'h00_0000);
    chk_regs("directed");
    repeat (300) begin
      lfsr = lfsr_next(lfsr);
      if (lfsr[0]) idle(1);
      exec(lfsr[31:16], lfsr[23:0]);
    end
    chk_regs("random");
    exec(16'h2094, 24'h00_0000);
    do_reset();
    chk_regs("reset");
    finish_test();
  end
endmodule : load_store_transfer_unit_tb
